/* File: inc/usp_defs.vh */
`ifndef USP_DEFS_VH
`define USP_DEFS_VH
`define USP_ADDR_STB     4'h0
`define USP_ADDR_TRP     4'h4
`define USP_ADDR_MISC    4'h8
`define USP_ADDR_STAT    4'hc
`define USP_STB0_LSB     0
`define USP_STB1_LSB     8
`define USP_STB_W        4
`define USP_TRP0_LSB     0
`define USP_TRP1_LSB     8
`define USP_TRP_W        5
`define USP_OVR_BIT      0
`define USP_STAT_W       3
`define USP_RST_STB      4'h0
`define USP_RST_TRP      5'h00
`define USP_DEF_STB      4'h3
`define USP_DEF_TRP      5'h07
`endif

/* File: design/usp_timer.v */
`timescale 1ns/100ps
// Down counter that stays busy for load value plus one cycles.
module usp_timer
#(
   parameter W = 5
)
(
   // Clock and reset.
   input  wire         clk_i,
   input  wire         rst_i,
   // Control.
   input  wire         start_i,
   input  wire [W-1:0] load_i,
   // Status.
   output reg          busy_o
);
   reg [W-1:0] count;

   // A start loads the count; busy ends one cycle after the count reaches zero.
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         count  <= {W{1'b0}};
         busy_o <= 1'b0;
      end
      else if (start_i)
      begin
         count  <= load_i;
         busy_o <= 1'b1;
      end
      else if (busy_o)
      begin
         if (count == {W{1'b0}})
            busy_o <= 1'b0;
         else
            count <= count - {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule

/* File: design/usp_top.v */
`timescale 1ns/100ps
`include "usp_defs.vh"
// Ultra-DMA strobe width and ready-to-pause timing with Wishbone registers.
module usp_top
(
   // Clock and reset.
   input  wire        clk_i,
   input  wire        rst_i,
   // Wishbone slave.
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [3:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // Transfer control.
   input  wire        burst_req_i,
   input  wire        target_slave_i,
   // Drive side strobes.
   output reg         drive_ready_strobe_o,
   output reg         pause_active_o,
   output reg         host_write_ok_o
);
   reg  [`USP_STB_W-1:0] master_strobe_width;
   reg  [`USP_STB_W-1:0] slave_strobe_width;
   reg  [`USP_TRP_W-1:0] master_ready_to_pause;
   reg  [`USP_TRP_W-1:0] slave_ready_to_pause;
   reg                   timing_override_bit;
   reg  [1:0]            state;
   reg                   tgt;
   reg                   strobe_start;
   reg                   pause_start;
   wire                  strobe_busy;
   wire                  pause_busy;
   wire [`USP_STB_W-1:0] sel_stb;
   wire [`USP_TRP_W-1:0] sel_trp;
   wire                  wb_go;
   wire [`USP_TRP_W-1:0] pick_stb;

   // Burst sequencer states.
   localparam ST_IDLE  = 2'b00;
   localparam ST_STB   = 2'b01;
   localparam ST_PAUSE = 2'b10;

   // Pick the field of the target drive, or the default when not overridden.
   function [`USP_TRP_W-1:0] pick;
      input                  ovr;
      input                  slv;
      input [`USP_TRP_W-1:0] m;
      input [`USP_TRP_W-1:0] s;
      input [`USP_TRP_W-1:0] d;
      begin
         if (!ovr)
            pick = d;
         else if (slv)
            pick = s;
         else
            pick = m;
      end
   endfunction

   // Write strobe for one register offset.
   function wr_hit;
      input       go;
      input       we;
      input [3:0] adr;
      input [3:0] off;
      begin
         wr_hit = go & we & (adr == off);
      end
   endfunction

   // Selected timing for the drive latched at burst start.
   assign pick_stb = pick(timing_override_bit, tgt,
                          {1'b0, master_strobe_width},
                          {1'b0, slave_strobe_width},
                          {1'b0, `USP_DEF_STB});
   // The width field is one bit narrower than the shared picker result.
   assign sel_stb = pick_stb[`USP_STB_W-1:0];
   assign sel_trp = pick(timing_override_bit, tgt,
                         master_ready_to_pause, slave_ready_to_pause,
                         `USP_DEF_TRP);
   assign wb_go   = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   // Width field plus one cycles of strobe.
   usp_timer #(.W(`USP_STB_W)) u_stb
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (strobe_start),
      .load_i  (sel_stb),
      .busy_o  (strobe_busy)
   );

   // Pause field plus one cycles of ready-to-pause spacing.
   usp_timer #(.W(`USP_TRP_W)) u_trp
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (pause_start),
      .load_i  (sel_trp),
      .busy_o  (pause_busy)
   );

   // Wishbone register writes and one-cycle acknowledge.
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o              <= 1'b0;
         master_strobe_width   <= `USP_RST_STB;
         slave_strobe_width    <= `USP_RST_STB;
         master_ready_to_pause <= `USP_RST_TRP;
         slave_ready_to_pause  <= `USP_RST_TRP;
         timing_override_bit   <= 1'b0;
      end
      else
      begin
         wb_ack_o <= wb_go;
         if (wr_hit(wb_go, wb_we_i, wb_adr_i, `USP_ADDR_STB))
         begin
            if (wb_sel_i[0])
               master_strobe_width <= wb_dat_i[`USP_STB0_LSB +: `USP_STB_W];
            if (wb_sel_i[1])
               slave_strobe_width <= wb_dat_i[`USP_STB1_LSB +: `USP_STB_W];
         end
         if (wr_hit(wb_go, wb_we_i, wb_adr_i, `USP_ADDR_TRP))
         begin
            if (wb_sel_i[0])
               master_ready_to_pause <= wb_dat_i[`USP_TRP0_LSB +: `USP_TRP_W];
            if (wb_sel_i[1])
               slave_ready_to_pause <= wb_dat_i[`USP_TRP1_LSB +: `USP_TRP_W];
         end
         if (wr_hit(wb_go, wb_we_i, wb_adr_i, `USP_ADDR_MISC) && wb_sel_i[0])
            timing_override_bit <= wb_dat_i[`USP_OVR_BIT];
      end
   end

   // Read data; unmapped addresses read as zero.
   always @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= 32'h0;
      else
      begin
         wb_dat_o <= 32'h0;
         case (wb_adr_i)
            `USP_ADDR_STB:
            begin
               wb_dat_o[`USP_STB0_LSB +: `USP_STB_W] <= master_strobe_width;
               wb_dat_o[`USP_STB1_LSB +: `USP_STB_W] <= slave_strobe_width;
            end
            `USP_ADDR_TRP:
            begin
               wb_dat_o[`USP_TRP0_LSB +: `USP_TRP_W] <= master_ready_to_pause;
               wb_dat_o[`USP_TRP1_LSB +: `USP_TRP_W] <= slave_ready_to_pause;
            end
            `USP_ADDR_MISC:
               wb_dat_o[`USP_OVR_BIT] <= timing_override_bit;
            `USP_ADDR_STAT:
               wb_dat_o[`USP_STAT_W-1:0] <= {tgt, state};
            default:
               wb_dat_o <= 32'h0;
         endcase
      end
   end

   // Strobe then pause sequence per burst request.
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state        <= ST_IDLE;
         tgt          <= 1'b0;
         strobe_start <= 1'b0;
         pause_start  <= 1'b0;
      end
      else
      begin
         strobe_start <= 1'b0;
         pause_start  <= 1'b0;
         case (state)
            ST_IDLE:
               if (burst_req_i && !strobe_start)
               begin
                  tgt          <= target_slave_i;
                  strobe_start <= 1'b1;
                  state        <= ST_STB;
               end
            ST_STB:
               if (!strobe_start && !strobe_busy)
               begin
                  pause_start <= 1'b1;
                  state       <= ST_PAUSE;
               end
            ST_PAUSE:
               if (!pause_start && !pause_busy)
                  state <= ST_IDLE;
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // Registered pin outputs; strobe high for field plus one cycles.
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         drive_ready_strobe_o <= 1'b0;
         pause_active_o       <= 1'b0;
         host_write_ok_o      <= 1'b1;
      end
      else
      begin
         drive_ready_strobe_o <= strobe_busy;
         pause_active_o       <= pause_busy;
         // Held low from burst start to pause end, gap cycles included.
         host_write_ok_o      <= (state == ST_IDLE) & ~pause_busy
                                 & ~strobe_busy;
      end
   end
endmodule

/* File: sim/usp_drive.sv */
`timescale 1ns/100ps
// Drive model: asks for a burst and times strobe and pause.
module usp_drive
(
   // Clock and reset.
   input  wire       clk_i,
   input  wire       rst_i,
   // Bench side.
   input  wire       go_i,
   output reg        done_o,
   output reg  [5:0] stb_len_o,
   output reg  [5:0] pause_len_o,
   // Controller side.
   input  wire       strobe_i,
   input  wire       pause_i,
   output reg        req_o
);
   reg pause_q;
   // Request is dropped once taken; done waits for the pause end.
   always @(posedge clk_i)
   begin
      if (rst_i)
         {req_o, done_o, stb_len_o, pause_len_o, pause_q} <= 15'h0;
      else
      begin
         pause_q <= pause_i;
         if (go_i)
            {req_o, done_o, stb_len_o, pause_len_o} <= 14'h2000;
         else if (strobe_i)
            req_o <= 1'b0;
         if (strobe_i)
            stb_len_o <= stb_len_o + 6'h1;
         if (pause_i)
            pause_len_o <= pause_len_o + 6'h1;
         if (pause_q && !pause_i)
            done_o <= 1'b1;
      end
   end
endmodule

/* File: sim/usp_top_asserts.sv */
`timescale 1ns/100ps
`include "usp_defs.vh"
// Checks strobe and pause lengths against shadowed registers.
module usp_top_asserts
(
   // Observed ports.
   input wire        clk_i,
   input wire        rst_i,
   input wire        wb_we_i,
   input wire [3:0]  wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire        wb_ack_o,
   input wire        target_slave_i,
   input wire        drive_ready_strobe_o,
   input wire        pause_active_o,
   input wire        host_write_ok_o
);
   reg [31:0] stb;
   reg [31:0] trp;
   reg        ovr;
   reg        tg;
   reg [5:0]  sc;
   reg [5:0]  pc;
   wire       wr = wb_ack_o && wb_we_i;
   wire       sf = !drive_ready_strobe_o && sc != 6'h0;
   wire       pf = !pause_active_o && pc != 6'h0;
   // Shadow writes, hold the target, count active cycles.
   always @(posedge clk_i)
   begin
      if (rst_i)
         {stb, trp, ovr, tg, sc, pc} <= 78'h0;
      else
      begin
         if (wr && wb_adr_i == `USP_ADDR_STB)
            stb <= wb_dat_i;
         if (wr && wb_adr_i == `USP_ADDR_TRP)
            trp <= wb_dat_i;
         if (wr && wb_adr_i == `USP_ADDR_MISC)
            ovr <= wb_dat_i[`USP_OVR_BIT];
         tg <= drive_ready_strobe_o ? tg : target_slave_i;
         sc <= drive_ready_strobe_o ? sc + 6'h1 : 6'h0;
         pc <= pause_active_o ? pc + 6'h1 : 6'h0;
      end
   end
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_slv_strobe: assert property (sf && ovr && tg
      |-> sc == stb[11:8] + 6'h1) else $error("slave strobe");
   a_mst_strobe: assert property (sf && ovr && !tg
      |-> sc == stb[3:0] + 6'h1) else $error("master strobe");
   a_strobe_span: assert property (sf |-> sc <= 6'h10)
      else $error("strobe span");
   a_slv_pause: assert property (pf && ovr && tg
      |-> pc == trp[12:8] + 6'h1) else $error("slave pause");
   a_mst_pause: assert property (pf && ovr && !tg
      |-> pc == trp[4:0] + 6'h1) else $error("master pause");
   a_pause_span: assert property (pf |-> pc <= 6'h20)
      else $error("pause span");
   a_def_strobe: assert property (sf && !ovr
      |-> sc == `USP_DEF_STB + 6'h1) else $error("default strobe");
   a_def_pause: assert property (pf && !ovr
      |-> pc == `USP_DEF_TRP + 6'h1) else $error("default pause");
   a_hold_write: assert property ($fell(drive_ready_strobe_o)
      |-> (!host_write_ok_o) [*3] ##0 pause_active_o) else $error("write gap");
   a_busy_write: assert property (pause_active_o
      || drive_ready_strobe_o |-> !host_write_ok_o) else $error("busy write");
   a_write_back: assert property ($fell(pause_active_o)
      |-> ##1 host_write_ok_o) else $error("write back");
   cover property (sf && ovr && tg);
   cover property (pc == 6'h20);
   cover property (pf && !ovr);
endmodule
bind usp_top usp_top_asserts usp_top_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .target_slave_i(target_slave_i),
   .drive_ready_strobe_o(drive_ready_strobe_o),
   .pause_active_o(pause_active_o), .host_write_ok_o(host_write_ok_o));

/* File: sim/usp_top_bench.sv */
`timescale 1ns/100ps
`include "usp_defs.vh"
// Register accesses and bursts with checked timing.
module usp_top_bench;
   reg         clk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg         cyc = 1'b0;
   reg         we = 1'b0;
   reg  [3:0]  adr = 4'h0;
   reg  [31:0] wdat = 32'h0;
   reg         tgt = 1'b0;
   reg         go = 1'b0;
   reg  [31:0] q;
   wire [31:0] rdat;
   wire [5:0]  sl;
   wire [5:0]  pl;
   wire        ack, req, strobe, pause, done;
   integer     fail_count = 0;
   integer     samples_checked = 0;
   // Free-running 50 MHz clock.
   always #10 clk_i = ~clk_i;
   usp_top usp_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .burst_req_i(req),
      .target_slave_i(tgt), .drive_ready_strobe_o(strobe),
      .pause_active_o(pause), .host_write_ok_o());
   usp_drive usp_drive_i (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
      .done_o(done), .stb_len_o(sl), .pause_len_o(pl), .strobe_i(strobe),
      .pause_i(pause), .req_o(req));
   task cmp(input [47:0] what, input [31:0] e, input [31:0] s);
   begin
      samples_checked = samples_checked + 1;
      if (s !== e)
      begin
         fail_count = fail_count + 1;
         $display("CHECK FAILED %0s expected %h seen %h", what, e, s);
      end
   end
   endtask
   task wb(input w, input [3:0] a, input [31:0] d);
   begin
      @(posedge clk_i);
      {cyc, we, adr, wdat} <= {1'b1, w, a, d};
      @(posedge clk_i);
      while (ack !== 1'b1)
         @(posedge clk_i);
      q = rdat;
      cyc <= 1'b0;
   end
   endtask
   task run(input t, input [5:0] es, input [5:0] ep);
   begin
      @(posedge clk_i);
      {tgt, go} <= {t, 1'b1};
      @(posedge clk_i);
      go <= 1'b0;
      @(posedge clk_i);
      while (done !== 1'b1)
         @(posedge clk_i);
      cmp("strobe", {26'h0, es}, {26'h0, sl});
      cmp("pause", {26'h0, ep}, {26'h0, pl});
   end
   endtask
   task print_verdict;
   begin
      if (fail_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask
   // Cuts a hang short.
   initial
   begin
      #200000;
      fail_count = fail_count + 1;
      print_verdict;
   end
   // Main sequence.
   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, `USP_ADDR_STB, 32'h0);
      cmp("stbreg", 32'h0, q);
      wb(1'b0, `USP_ADDR_TRP, 32'h0);
      cmp("trpreg", 32'h0, q);
      run(1'b0, 6'h4, 6'h8);
      wb(1'b1, `USP_ADDR_MISC, 32'h1);
      wb(1'b0, `USP_ADDR_MISC, 32'h0);
      cmp("misc", 32'h1, q);
      wb(1'b1, `USP_ADDR_STB, 32'hffffffff);
      wb(1'b0, `USP_ADDR_STB, 32'h0);
      cmp("stbreg", 32'h00000f0f, q);
      wb(1'b1, `USP_ADDR_TRP, 32'hffffffff);
      wb(1'b0, `USP_ADDR_TRP, 32'h0);
      cmp("trpreg", 32'h00001f1f, q);
      wb(1'b1, `USP_ADDR_STB, 32'h00000f00);
      wb(1'b1, `USP_ADDR_TRP, 32'h00001f00);
      run(1'b0, 6'h1, 6'h1);
      run(1'b1, 6'h10, 6'h20);
      wb(1'b0, `USP_ADDR_STAT, 32'h0);
      cmp("status", 32'h4, q);
      wb(1'b1, `USP_ADDR_MISC, 32'h0);
      run(1'b1, 6'h4, 6'h8);
      print_verdict;
   end
endmodule
